/* File: src/boolean_shift_unit_60b.sv */
// 60-bit boolean and shift functional unit, one register stage deep
// assumes: operands and index are presented with the parcel in the issue cycle,
// and the register file writes result_out into result_dest_out when valid
//
// What this block does
// - difference is first xor inverted second
// - immediate left shift rotates destination in place
// - j and k form six-bit immediate count
// - immediate right shift sign-shifts destination in place
// - circular shift keeps bits and their order
// - arithmetic shift fills top with sign copies
// - index left shift: positive rotates, negative shifts
// - legacy negative overflow bits 6-10 give +0
// - extended negative overflow bits 6-11 give -0
// - extended zero index copies operand unaltered
// - extended positive: low six bits, modulo 60
// - extended negative: complement 12 bits, big fills sign
// - all-ones and all-zeros operands not special
// - legacy index right shift: positive shifts, negative rotates
// - legacy positive overflow bits 6-10 give +0
// - index is 18-bit ones-complement, sign on top
`timescale 1ns/100ps
`include "bsu_defs.svh"

module boolean_shift_unit_60b
  import bsu_pkg::*;
(
  input  wire logic                       clk_sys_in,
  input  wire logic                       rstn_in,
  input  wire logic                       issue_valid_in,
  input  wire logic [`BSU_PARCEL_W-1:0]   instr_parcel_in,
  input  wire logic                       extended_variant_in,
  input  wire logic [`BSU_WORD_W-1:0]     result_operand_reg_in,
  input  wire logic [`BSU_WORD_W-1:0]     first_operand_reg_in,
  input  wire logic [`BSU_WORD_W-1:0]     second_operand_reg_in,
  input  wire logic [`BSU_INDEX_W-1:0]    shift_index_reg_in,
  output logic                            result_valid_out,
  output logic                            unsupported_out,
  output logic [2:0]                      result_dest_out,
  output logic [`BSU_WORD_W-1:0]          result_out
);

  // ones-complement sign sits in the top index bit
  function automatic logic index_negative(input index_t idx);
    index_negative = idx[`BSU_IDX_SIGN];
  endfunction : index_negative

  // true when every bit of the tested span differs from none of the sign
  function automatic logic span_matches_sign(input index_t idx, input int unsigned msb);
    logic ok;
    ok = 1'b1;
    for (int unsigned b = `BSU_TEST_LSB; b <= `BSU_EXT_TEST_MSB; b++) begin
      if (b <= msb && idx[b] != idx[`BSU_IDX_SIGN]) begin
        ok = 1'b0;
      end
    end
    span_matches_sign = ok;
  endfunction : span_matches_sign

  // parcel fields
  logic [5:0]  legacy_opcode_field;
  logic [5:0]  extended_opcode_field;
  logic [2:0]  dest_field;
  count_t      immediate_shift_count;

  assign legacy_opcode_field   = instr_parcel_in[`BSU_OPC_MSB:`BSU_OPC_LSB];
  assign extended_opcode_field = instr_parcel_in[`BSU_OPC_MSB:`BSU_OPC_LSB];
  assign dest_field            = instr_parcel_in[`BSU_DEST_MSB:`BSU_DEST_LSB];
  // j and k designators read as one unsigned count
  assign immediate_shift_count = {instr_parcel_in[`BSU_FIRST_MSB:`BSU_FIRST_LSB],
                                  instr_parcel_in[`BSU_SECOND_MSB:`BSU_SECOND_LSB]};

  variant_t  variant;
  logic [5:0] opcode;
  assign variant = extended_variant_in ? VAR_EXTENDED : VAR_LEGACY;
  assign opcode  = (variant == VAR_EXTENDED) ? extended_opcode_field : legacy_opcode_field;

  logic is_diff;
  logic is_lsh_imm;
  logic is_rsh_imm;
  logic is_lsh_idx;
  logic is_rsh_idx;
  logic op_known;

  assign is_diff    = (opcode == `BSU_OP_DIFF_CMPL);
  assign is_lsh_imm = (opcode == `BSU_OP_LSH_IMM);
  assign is_rsh_imm = (opcode == `BSU_OP_RSH_IMM);
  assign is_lsh_idx = (opcode == `BSU_OP_LSH_IDX);
  // the extended right shift by index is not carried by this unit
  assign is_rsh_idx = (opcode == `BSU_OP_RSH_IDX) && (variant == VAR_LEGACY);
  assign op_known   = is_diff | is_lsh_imm | is_rsh_imm | is_lsh_idx | is_rsh_idx;

  // index tests
  index_t idx;
  logic   idx_neg;
  logic   legacy_left_over;
  logic   legacy_right_over;
  logic   ext_over;
  logic   ext_zero;
  count_t idx_count;
  logic [`BSU_WIDE_COUNT_W-1:0] ext_wide_count;
  logic   ext_wide_big;

  assign idx     = shift_index_reg_in;
  assign idx_neg = index_negative(idx);
  // negative index past 63 places right; bits 11-16 untested
  assign legacy_left_over  = idx_neg && !span_matches_sign(idx, `BSU_LEG_TEST_MSB);
  // positive index past 63 places right; bits 11-16 untested
  assign legacy_right_over = !idx_neg && !span_matches_sign(idx, `BSU_LEG_TEST_MSB);
  // negative index past 63 places; bits 12-16 untested
  assign ext_over = idx_neg && !span_matches_sign(idx, `BSU_EXT_TEST_MSB);
  // both encodings of zero
  assign ext_zero = (idx == '0) || (idx == '1);
  // negative magnitude is the complement of the low bits
  assign idx_count = idx_neg ? count_t'(~idx[`BSU_COUNT_W-1:0]) : idx[`BSU_COUNT_W-1:0];
  // twelve-bit complemented count for extended left shifts by a negative index
  assign ext_wide_count = ~idx[`BSU_WIDE_COUNT_W-1:0];
  assign ext_wide_big   = idx_neg && (ext_wide_count > `BSU_WIDE_LIMIT);

  // shifter request
  shift_if sh_bus ();
  shift_core u_shift_core (
    .sh (sh_bus.shifter)
  );

  word_t      sh_operand;
  count_t     sh_count;
  shift_dir_t sh_dir;

  // immediate shifts act on the destination register itself
  assign sh_operand = (is_lsh_imm || is_rsh_imm) ? result_operand_reg_in : second_operand_reg_in;
  // extended positive count is low six bits, wrapped at 60 by the shifter
  assign sh_count   = (is_lsh_imm || is_rsh_imm) ? immediate_shift_count : idx_count;
  // left-by-index rotates on positive, shifts on negative
  // right-by-index shifts on positive, rotates on negative
  assign sh_dir     = is_rsh_imm                   ? DIR_ASR :
                      (is_lsh_idx &&  idx_neg)     ? DIR_ASR :
                      (is_rsh_idx && !idx_neg)     ? DIR_ASR : DIR_ROTL;

  assign sh_bus.operand = sh_operand;
  assign sh_bus.count   = sh_count;
  assign sh_bus.dir     = sh_dir;

  // result selection; the data path never looks at operand patterns
  word_t diff_word;
  word_t sign_fill;
  word_t lsh_idx_word;
  word_t rsh_idx_word;
  word_t result_nxt;

  assign diff_word = first_operand_reg_in ^ ~second_operand_reg_in;
  assign sign_fill = {`BSU_WORD_W{second_operand_reg_in[`BSU_WORD_W-1]}};

  assign lsh_idx_word = (variant == VAR_LEGACY) ? (legacy_left_over ? word_t'(0) : sh_bus.result) :
                        ext_zero               ? second_operand_reg_in :
                        ext_over               ? word_t'('1) :
                        ext_wide_big           ? sign_fill : sh_bus.result;
  assign rsh_idx_word = legacy_right_over ? word_t'(0) : sh_bus.result;

  assign result_nxt = is_diff                  ? diff_word :
                      (is_lsh_imm | is_rsh_imm) ? sh_bus.result :
                      is_lsh_idx               ? lsh_idx_word :
                      is_rsh_idx               ? rsh_idx_word : word_t'(`BSU_RESULT_RST);

  // single stage: every operation and operand has the same one-cycle latency
  logic       valid_nxt;
  logic       unsupported_nxt;
  logic [2:0] dest_nxt;

  assign valid_nxt       = issue_valid_in && op_known;
  assign unsupported_nxt = issue_valid_in && !op_known;
  assign dest_nxt        = op_known ? dest_field : `BSU_DEST_RST;

  logic       result_valid_r;
  logic       unsupported_r;
  logic [2:0] result_dest_r;
  word_t      result_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      result_valid_r <= 1'b0;
      unsupported_r  <= 1'b0;
    end else begin
      result_valid_r <= valid_nxt;
      unsupported_r  <= unsupported_nxt;
    end
  end

  // data only loads on a taken operation so the last result stays visible
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      result_r      <= `BSU_RESULT_RST;
      result_dest_r <= `BSU_DEST_RST;
    end else if (valid_nxt) begin
      result_r      <= result_nxt;
      result_dest_r <= dest_nxt;
    end
  end

  assign result_valid_out = result_valid_r;
  assign unsupported_out  = unsupported_r;
  assign result_dest_out  = result_dest_r;
  assign result_out       = result_r;

endmodule : boolean_shift_unit_60b

/* File: src/bsu_defs.svh */
// constants of the 60-bit boolean and shift unit
// assumes: included by the package and by every design file that needs a figure
`ifndef BSU_DEFS_SVH
`define BSU_DEFS_SVH

`define BSU_WORD_W        60
`define BSU_INDEX_W       18
`define BSU_PARCEL_W      15
`define BSU_COUNT_W       6
`define BSU_WIDE_COUNT_W  12
`define BSU_ROT_MODULUS   6'h3C
`define BSU_WIDE_LIMIT    12'h03C

`define BSU_OPC_MSB       14
`define BSU_OPC_LSB       9
`define BSU_DEST_MSB      8
`define BSU_DEST_LSB      6
`define BSU_FIRST_MSB     5
`define BSU_FIRST_LSB     3
`define BSU_SECOND_MSB    2
`define BSU_SECOND_LSB    0

`define BSU_IDX_SIGN      17
`define BSU_LEG_TEST_MSB  10
`define BSU_EXT_TEST_MSB  11
`define BSU_TEST_LSB      6

`define BSU_OP_DIFF_CMPL  6'h0F
`define BSU_OP_LSH_IMM    6'h10
`define BSU_OP_RSH_IMM    6'h11
`define BSU_OP_LSH_IDX    6'h12
`define BSU_OP_RSH_IDX    6'h13

`define BSU_LATENCY       1
`define BSU_RESULT_RST    60'h000000000000000
`define BSU_DEST_RST      3'h0

`endif

/* File: src/bsu_pkg.sv */
// types shared by the boolean and shift unit and its shifter
// assumes: constants come from the guarded defs header
`include "bsu_defs.svh"

package bsu_pkg;

  typedef logic [`BSU_WORD_W-1:0]   word_t;
  typedef logic [`BSU_INDEX_W-1:0]  index_t;
  typedef logic [`BSU_COUNT_W-1:0]  count_t;

  typedef enum logic {
    DIR_ROTL = 1'b0,
    DIR_ASR  = 1'b1
  } shift_dir_t;

  typedef enum logic {
    VAR_LEGACY   = 1'b0,
    VAR_EXTENDED = 1'b1
  } variant_t;

endpackage : bsu_pkg

/* File: src/shift_if.sv */
// bundle between the unit's control and its barrel shifter
// assumes: purely combinational traffic inside one clock domain
`timescale 1ns/100ps

interface shift_if;
  import bsu_pkg::*;

  word_t      operand;
  count_t     count;
  shift_dir_t dir;
  word_t      result;

  modport requester (output operand, output count, output dir, input result);
  modport shifter   (input operand, input count, input dir, output result);
endinterface : shift_if

/* File: src/shift_core.sv */
// combinational 60-bit barrel shifter: left circular or right arithmetic
// assumes: count is an unsigned 6-bit figure, valid in the same cycle
`timescale 1ns/100ps
`include "bsu_defs.svh"

module shift_core
  import bsu_pkg::*;
(
  shift_if.shifter sh
);

  count_t                    rot_count;
  logic [2*`BSU_WORD_W-1:0]  doubled;
  word_t                     rot_word;
  word_t                     asr_word;

  // a rotate of 60 or more places wraps round the word
  assign rot_count = (sh.count >= `BSU_ROT_MODULUS) ? count_t'(sh.count - `BSU_ROT_MODULUS)
                                                    : sh.count;
  // top bits leave and re-enter at the bottom in order, so ones are kept
  assign doubled  = {sh.operand, sh.operand} << rot_count;
  assign rot_word = doubled[2*`BSU_WORD_W-1:`BSU_WORD_W];
  // low bits drop off, sign copies fill from the top; 60+ gives all sign
  assign asr_word = word_t'($signed(sh.operand) >>> sh.count);

  assign sh.result = (sh.dir == DIR_ASR) ? asr_word : rot_word;

endmodule : shift_core

/* File: testbench/bsu_asserts.sv */
// port checker for the boolean and shift unit
// assumes: bound into boolean_shift_unit_60b, one clock domain
`timescale 1ns/100ps
module bsu_asserts
  import bsu_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic        issue_valid_in,
  input wire logic [14:0] instr_parcel_in,
  input wire logic        extended_variant_in,
  input wire logic [59:0] result_operand_reg_in,
  input wire logic [59:0] first_operand_reg_in,
  input wire logic [59:0] second_operand_reg_in,
  input wire logic [17:0] shift_index_reg_in,
  input wire logic        result_valid_out,
  input wire logic        unsupported_out,
  input wire logic [2:0]  result_dest_out,
  input wire logic [59:0] result_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire logic [5:0]  opc = instr_parcel_in[14:9];
  wire logic [17:0] ix  = shift_index_reg_in;
  wire logic        go  = issue_valid_in;
  wire logic        ext = extended_variant_in;
  property p_diff; go && opc == 6'h0F |=> result_out == ($past(first_operand_reg_in) ^ ~$past(second_operand_reg_in)); endproperty
  a_diff: assert property (p_diff) else $error("difference result wrong");
  property p_rot; go && opc == 6'h10 |=> $countones(result_out) == $countones($past(result_operand_reg_in)); endproperty
  a_rot: assert property (p_rot) else $error("rotate lost bits");
  property p_asr; go && opc == 6'h11 |=> result_out[59] == $past(result_operand_reg_in[59]); endproperty
  a_asr: assert property (p_asr) else $error("sign fill wrong");
  property p_leg_neg; go && opc == 6'h12 && !ext && ix[17] && ix[10:6] != 5'h1F |=> result_out == 60'h0; endproperty
  a_leg_neg: assert property (p_leg_neg) else $error("legacy overflow not zero");
  property p_ext_neg; go && opc == 6'h12 && ext && ix[17] && ix[11:6] != 6'h3F |=> &result_out; endproperty
  a_ext_neg: assert property (p_ext_neg) else $error("extended overflow not minus zero");
  property p_ext_zero; go && opc == 6'h12 && ext && (ix == 18'h0 || &ix) |=> result_out == $past(second_operand_reg_in);
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("zero index altered operand");
  property p_leg_pos; go && opc == 6'h13 && !ext && !ix[17] && ix[10:6] != 5'h0 |=> result_out == 60'h0; endproperty
  a_leg_pos: assert property (p_leg_pos) else $error("legacy right overflow not zero");
  property p_lat; go && opc inside {[6'h0F:6'h12]} |=> result_valid_out && !unsupported_out
    && result_dest_out == $past(instr_parcel_in[8:6]); endproperty
  a_lat: assert property (p_lat) else $error("result not delivered");
  property p_refuse; go && opc == 6'h13 && ext |=> unsupported_out && !result_valid_out; endproperty
  a_refuse: assert property (p_refuse) else $error("refused request not flagged");
endmodule : bsu_asserts

bind boolean_shift_unit_60b bsu_asserts u_bsu_asserts (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
  .issue_valid_in(issue_valid_in), .instr_parcel_in(instr_parcel_in), .extended_variant_in(extended_variant_in),
  .result_operand_reg_in(result_operand_reg_in), .first_operand_reg_in(first_operand_reg_in),
  .second_operand_reg_in(second_operand_reg_in), .shift_index_reg_in(shift_index_reg_in),
  .result_valid_out(result_valid_out), .unsupported_out(unsupported_out), .result_dest_out(result_dest_out),
  .result_out(result_out));

/* File: testbench/bsu_regfile_model.sv */
// register file standing in for issue and write-back
// assumes: parcel fields name the registers directly
`timescale 1ns/100ps
module bsu_regfile_model
  import bsu_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        load_en_in,
  input  wire logic [2:0]  load_addr_in,
  input  wire word_t       load_data_in,
  input  wire logic [14:0] parcel_in,
  input  wire logic        wb_en_in,
  input  wire logic [2:0]  wb_addr_in,
  input  wire word_t       wb_data_in,
  output word_t            dest_word_out,
  output word_t            first_word_out,
  output word_t            second_word_out
);
  word_t xr [8] = '{default: '0};
  // load wins over write-back so fresh data keeps arriving
  always @(posedge clk_sys_in) begin
    if (wb_en_in) xr[wb_addr_in] <= wb_data_in;
    if (load_en_in) xr[load_addr_in] <= load_data_in;
  end
  assign dest_word_out   = xr[parcel_in[8:6]];
  assign first_word_out  = xr[parcel_in[5:3]];
  assign second_word_out = xr[parcel_in[2:0]];
endmodule : bsu_regfile_model

/* File: testbench/boolean_shift_unit_60b_tb_top.sv */
// random self-checking bench with a reference model
// assumes: operands come from the register file model
`timescale 1ns/100ps
module boolean_shift_unit_60b_tb_top
  import bsu_pkg::*;
;
  logic        clk_sys_in = 0, rstn_in = 0, issue_valid_in = 0, extended_variant_in = 0;
  logic        ld_en = 0, vld, uns, pv = 0, pok = 0;
  logic [14:0] parcel = '0;
  logic [17:0] idx = '0;
  logic [2:0]  ld_addr = '0, dest, exp_dest = '0;
  word_t       ld_data = '0, op_d, op_a, op_b, res, r, exp_res = '0;
  int          n_fail = 0, compares = 0, k;

  boolean_shift_unit_60b u_boolean_shift_unit_60b (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .issue_valid_in(issue_valid_in), .instr_parcel_in(parcel), .extended_variant_in(extended_variant_in),
    .result_operand_reg_in(op_d), .first_operand_reg_in(op_a), .second_operand_reg_in(op_b),
    .shift_index_reg_in(idx), .result_valid_out(vld), .unsupported_out(uns), .result_dest_out(dest),
    .result_out(res));
  bsu_regfile_model u_bsu_regfile_model (.clk_sys_in(clk_sys_in), .load_en_in(ld_en), .load_addr_in(ld_addr),
    .load_data_in(ld_data), .parcel_in(parcel), .wb_en_in(vld), .wb_addr_in(dest), .wb_data_in(res),
    .dest_word_out(op_d), .first_word_out(op_a), .second_word_out(op_b));

  initial forever #10 clk_sys_in = ~clk_sys_in;

  task end_of_test;
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  function automatic word_t rotl(word_t x, int c);
    logic [119:0] t;
    t = {x, x} << c;
    return t[119:60];
  endfunction : rotl

  function automatic word_t asr(word_t x, int c);
    if (c >= 60) return {60{x[59]}};
    return $signed(x) >>> c;
  endfunction : asr

  function automatic bit model(output word_t q);
    logic [5:0]  n6;
    logic [11:0] n12;
    n6 = ~idx[5:0];
    n12 = ~idx[11:0];
    q = '0;
    case (parcel[14:9])
      6'h0F: q = op_a ^ ~op_b;
      6'h10: q = rotl(op_d, parcel[5:0] % 60);
      6'h11: q = asr(op_d, parcel[5:0]);
      6'h12: if (extended_variant_in)
          q = (idx == 0 || &idx) ? op_b : !idx[17] ? rotl(op_b, idx[5:0] % 60)
          : idx[11:6] != 6'h3F ? '1 : asr(op_b, n12);
        else q = !idx[17] ? rotl(op_b, idx[5:0] % 60) : idx[10:6] != 5'h1F ? '0 : asr(op_b, n6);
      6'h13: if (extended_variant_in) return 0;
        else q = idx[17] ? rotl(op_b, n6 % 60) : idx[10:6] != 5'h0 ? '0 : asr(op_b, idx[5:0]);
      default: return 0;
    endcase
    return 1;
  endfunction : model

  // all-ones and all-zeros words are frequent on purpose
  function automatic word_t rw();
    k = $urandom % 4;
    return k == 0 ? '0 : k == 1 ? '1 : word_t'({$urandom, $urandom});
  endfunction : rw

  initial begin
    repeat (10000) @(posedge clk_sys_in);
    n_fail++;
    end_of_test();
  end

  initial begin
    r = word_t'($urandom(32'h0824));
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    rstn_in = 1;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_sys_in);
      check(vld, pv && pok);
      check(uns, pv && !pok);
      check(res, exp_res);
      check(dest, exp_dest);
      rstn_in = (i % 1000 != 999);
      issue_valid_in = ($urandom % 8 != 0);
      extended_variant_in = 1'($urandom);
      k = $urandom % 7;
      parcel = {(k < 5) ? 6'(k + 15) : 6'($urandom), 9'($urandom)};
      idx = 18'($urandom);
      case ($urandom % 4)
        1: idx[17:6] = '0;
        2: idx[17:6] = '1;
        3: idx = {18{idx[0]}};
        default: ;
      endcase
      ld_en = 1'($urandom);
      ld_addr = 3'($urandom);
      ld_data = rw();
      #1;
      pv = issue_valid_in && rstn_in;
      pok = model(r);
      if (pv && pok) begin
        exp_res = r;
        exp_dest = parcel[8:6];
      end
      if (!rstn_in) begin
        exp_res = '0;
        exp_dest = '0;
      end
    end
    end_of_test();
  end
endmodule : boolean_shift_unit_60b_tb_top
